// File: design/rxie_consts.svh
// Register offsets, field positions and reset values of the receive-port interrupt block
`ifndef RXIE_CONSTS_SVH
`define RXIE_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RXIE_ADDR_EN_UPPER      8'hD8
`define RXIE_ADDR_EN_LOWER      8'hD9
`define RXIE_ADDR_PEND_UPPER    8'hDA
`define RXIE_ADDR_PEND_LOWER    8'hDB
`define RXIE_ADDR_STATUS_FIRST  8'hE0
`define RXIE_ADDR_STATUS_SECOND 8'hE1

// ****************************************************************
// Reset values
// ****************************************************************
`define RXIE_RST_EN_UPPER       3'h0
`define RXIE_RST_EN_LOWER       8'h00
`define RXIE_RST_RDATA          8'h00

// ****************************************************************
// Upper enable and pending bit positions
// ****************************************************************
`define RXIE_UP_CODING          2
`define RXIE_UP_ORDER           1
`define RXIE_UP_CHECK           0

// ****************************************************************
// Lower enable and pending bit positions
// ****************************************************************
`define RXIE_LO_LENGTH          6
`define RXIE_LO_COUNT           5
`define RXIE_LO_OVERFLOW        4
`define RXIE_LO_PARITY          2
`define RXIE_LO_PORT            1
`define RXIE_LO_LOCK            0

// ****************************************************************
// Internal pending vector positions
// ****************************************************************
`define RXIE_F_CHECK            0
`define RXIE_F_ORDER            1
`define RXIE_F_CODING           2
`define RXIE_F_LOCK             3
`define RXIE_F_PORT             4
`define RXIE_F_PARITY           5
`define RXIE_F_OVERFLOW         6
`define RXIE_F_COUNT            7
`define RXIE_F_LENGTH           8

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define RXIE_S1_LOCK_CHG        0
`define RXIE_S1_PORT_VALID      1
`define RXIE_S1_PARITY          2
`define RXIE_S1_CHECK           3
`define RXIE_S1_ORDER           4
`define RXIE_S1_LOCK            5
`define RXIE_S2_COUNT           0
`define RXIE_S2_LENGTH          1
`define RXIE_S2_CODING          2
`define RXIE_S2_OVERFLOW        3

`endif

// File: design/rxie_pkg.sv
// State types of the receive-port interrupt block
package rxie_pkg;

  localparam int FLAG_N = 9;

  typedef struct packed {
    logic [FLAG_N-1:0] flags;
  } rxie_flag_state_t;

  typedef struct packed {
    logic [15:0] prev;
    logic        primed;
    logic        change;
  } rxie_chg_state_t;

  typedef struct packed {
    logic [2:0] en_upper;
    logic [7:0] en_lower;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
  } rxie_top_state_t;

endpackage : rxie_pkg

// File: design/rxie_change_det.sv
// Change detector that pulses when a sampled value differs from the last one
module rxie_change_det
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_value,
  output logic             o_change
);

  rxie_pkg::rxie_chg_state_t st_reg;
  rxie_pkg::rxie_chg_state_t st_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next        = st_reg;
    st_next.prev   = i_value;
    st_next.primed = 1'b1;
    // First sample after reset only primes the reference
    st_next.change = st_reg.primed && (i_value != st_reg.prev);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_change = st_reg.change;

endmodule : rxie_change_det

// File: design/rxie_flag_bank.sv
// Sticky pending flags, set by events and cleared per bit, set winning
module rxie_flag_bank
(
  input  wire logic                      i_clock,
  input  wire logic                      i_nrst,
  input  wire logic [rxie_pkg::FLAG_N-1:0] i_set,
  input  wire logic [rxie_pkg::FLAG_N-1:0] i_clr,
  output logic      [rxie_pkg::FLAG_N-1:0] o_flags
);

  rxie_pkg::rxie_flag_state_t   st_reg;
  rxie_pkg::rxie_flag_state_t   st_next;
  logic [rxie_pkg::FLAG_N-1:0]  bit_next;

  // ****************************************************************
  // Per-bit update
  // ****************************************************************
  for (genvar i = 0; i < rxie_pkg::FLAG_N; i++)
  begin : g_flag
    assign bit_next[i] = i_set[i] | (st_reg.flags[i] & ~i_clr[i]);
  end

  always_comb
  begin
    st_next       = st_reg;
    st_next.flags = bit_next;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_flags = st_reg.flags;

endmodule : rxie_flag_bank

// File: design/rxie_top.sv
// Receive-port interrupt enables, pending flags, read-clear status and interrupt output
`include "rxie_consts.svh"

// Contract
// - Upper enable bit 2 lets link coding errors raise the interrupt.
// - Upper enable bit 1 lets control channel order errors raise the interrupt.
// - Upper enable bit 0 lets control channel check failures raise the interrupt.
// - Lower enable bit 6 lets line length changes raise the interrupt.
// - Lower enable bit 5 lets line count changes raise the interrupt.
// - Lower enable bit 4 lets receive overflow raise the interrupt.
// - Lower enable bit 2 lets link parity errors raise the interrupt.
// - Lower enable bit 1 lets port-valid changes raise the interrupt.
// - Lower enable bit 0 lets lock changes raise the interrupt.
// - Reading first status clears order, check, parity, port and lock flags.
// - Reading second status clears length, count, overflow and coding flags.
module rxie_top
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [7:0]  O_REG_RDATA,
  output logic             O_REG_RVALID,
  input  wire logic        I_LINK_CODING_ERR,
  input  wire logic        I_CTRL_CHAN_ORDER_ERR,
  input  wire logic        I_CTRL_CHAN_CHECK_ERR,
  input  wire logic        I_LINK_PARITY_ERR,
  input  wire logic        I_RX_OVERFLOW,
  input  wire logic        I_LOCK,
  input  wire logic        I_PORT_VALID,
  input  wire logic [15:0] I_LINE_LENGTH,
  input  wire logic [15:0] I_LINE_COUNT,
  output logic             O_IRQ
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rxie_pkg::rxie_top_state_t     st_reg;
  rxie_pkg::rxie_top_state_t     st_next;
  logic [rxie_pkg::FLAG_N-1:0]   flags;
  logic [rxie_pkg::FLAG_N-1:0]   ev_set;
  logic [rxie_pkg::FLAG_N-1:0]   ev_clr;
  logic [rxie_pkg::FLAG_N-1:0]   enables;
  logic                          lock_chg;
  logic                          port_chg;
  logic                          length_chg;
  logic                          count_chg;
  logic                          rd_first;
  logic                          rd_second;
  logic                          wr_upper;
  logic                          wr_lower;
  logic [rxie_pkg::FLAG_N-1:0]   pend_hit;
  logic [15:0]                   lock_value;
  logic [15:0]                   port_value;

  // ****************************************************************
  // Address match used by read-clear and write decode paths
  // ****************************************************************
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction : addr_is

  // ****************************************************************
  // Level and value change detectors
  // ****************************************************************
  // Each detector needs one edge after reset before it can report a change
  // Single-bit levels share the sixteen-bit detector, zero extended
  assign lock_value = {15'h0000, I_LOCK};
  assign port_value = {15'h0000, I_PORT_VALID};

  rxie_change_det u_lock_chg
  (
    .i_clock  (I_CLOCK),
    .i_nrst   (I_NRST),
    .i_value  (lock_value),
    .o_change (lock_chg)
  );

  rxie_change_det u_port_chg
  (
    .i_clock  (I_CLOCK),
    .i_nrst   (I_NRST),
    .i_value  (port_value),
    .o_change (port_chg)
  );

  rxie_change_det u_length_chg
  (
    .i_clock  (I_CLOCK),
    .i_nrst   (I_NRST),
    .i_value  (I_LINE_LENGTH),
    .o_change (length_chg)
  );

  rxie_change_det u_count_chg
  (
    .i_clock  (I_CLOCK),
    .i_nrst   (I_NRST),
    .i_value  (I_LINE_COUNT),
    .o_change (count_chg)
  );

  // ****************************************************************
  // Event sources into the pending flags
  // ****************************************************************
  // Pulse inputs set their flag at the edge that samples them;
  // level and value changes set theirs one edge later, via the detectors
  always_comb
  begin
    ev_set                   = '0;
    ev_set[`RXIE_F_CODING]   = I_LINK_CODING_ERR;
    ev_set[`RXIE_F_ORDER]    = I_CTRL_CHAN_ORDER_ERR;
    ev_set[`RXIE_F_CHECK]    = I_CTRL_CHAN_CHECK_ERR;
    ev_set[`RXIE_F_LENGTH]   = length_chg;
    ev_set[`RXIE_F_COUNT]    = count_chg;
    ev_set[`RXIE_F_OVERFLOW] = I_RX_OVERFLOW;
    ev_set[`RXIE_F_PARITY]   = I_LINK_PARITY_ERR;
    ev_set[`RXIE_F_PORT]     = port_chg;
    ev_set[`RXIE_F_LOCK]     = lock_chg;
  end

  // ****************************************************************
  // Read-to-clear of the status registers
  // ****************************************************************
  assign rd_first  = I_REG_RD && addr_is(I_REG_ADDR, `RXIE_ADDR_STATUS_FIRST);
  assign rd_second = I_REG_RD && addr_is(I_REG_ADDR, `RXIE_ADDR_STATUS_SECOND);

  // ****************************************************************
  // Write decode of the two enable registers
  // ****************************************************************
  // Writes to any other address are ignored
  assign wr_upper  = I_REG_WR && addr_is(I_REG_ADDR, `RXIE_ADDR_EN_UPPER);
  assign wr_lower  = I_REG_WR && addr_is(I_REG_ADDR, `RXIE_ADDR_EN_LOWER);

  always_comb
  begin
    ev_clr                   = '0;
    ev_clr[`RXIE_F_ORDER]    = rd_first;
    ev_clr[`RXIE_F_CHECK]    = rd_first;
    ev_clr[`RXIE_F_PARITY]   = rd_first;
    ev_clr[`RXIE_F_PORT]     = rd_first;
    ev_clr[`RXIE_F_LOCK]     = rd_first;
    ev_clr[`RXIE_F_LENGTH]   = rd_second;
    ev_clr[`RXIE_F_COUNT]    = rd_second;
    ev_clr[`RXIE_F_OVERFLOW] = rd_second;
    ev_clr[`RXIE_F_CODING]   = rd_second;
  end

  // Set wins over a clear in the same cycle
  rxie_flag_bank u_flags
  (
    .i_clock  (I_CLOCK),
    .i_nrst   (I_NRST),
    .i_set    (ev_set),
    .i_clr    (ev_clr),
    .o_flags  (flags)
  );

  // ****************************************************************
  // Enable vector in pending order
  // ****************************************************************
  always_comb
  begin
    enables                   = '0;
    enables[`RXIE_F_CODING]   = st_reg.en_upper[`RXIE_UP_CODING];
    enables[`RXIE_F_ORDER]    = st_reg.en_upper[`RXIE_UP_ORDER];
    enables[`RXIE_F_CHECK]    = st_reg.en_upper[`RXIE_UP_CHECK];
    enables[`RXIE_F_LENGTH]   = st_reg.en_lower[`RXIE_LO_LENGTH];
    enables[`RXIE_F_COUNT]    = st_reg.en_lower[`RXIE_LO_COUNT];
    enables[`RXIE_F_OVERFLOW] = st_reg.en_lower[`RXIE_LO_OVERFLOW];
    enables[`RXIE_F_PARITY]   = st_reg.en_lower[`RXIE_LO_PARITY];
    enables[`RXIE_F_PORT]     = st_reg.en_lower[`RXIE_LO_PORT];
    enables[`RXIE_F_LOCK]     = st_reg.en_lower[`RXIE_LO_LOCK];
  end

  // ****************************************************************
  // Pending conditions whose enable is set
  // ****************************************************************
  // The interrupt is registered from these, so it trails by one edge
  assign pend_hit = flags & enables;

  // ****************************************************************
  // Read data assembly
  // ****************************************************************
  function automatic logic [7:0] read_byte
  (
    input logic [7:0]                  addr,
    input logic [2:0]                  en_up,
    input logic [7:0]                  en_lo,
    input logic [rxie_pkg::FLAG_N-1:0] f,
    input logic                        lock,
    input logic                        port_valid
  );
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      `RXIE_ADDR_EN_UPPER:
      begin
        // Bits 7:3 read back as zero
        d[2:0] = en_up;
      end
      `RXIE_ADDR_EN_LOWER:
      begin
        d = en_lo;
      end
      `RXIE_ADDR_PEND_UPPER:
      begin
        d[`RXIE_UP_CODING] = f[`RXIE_F_CODING];
        d[`RXIE_UP_ORDER]  = f[`RXIE_F_ORDER];
        d[`RXIE_UP_CHECK]  = f[`RXIE_F_CHECK];
      end
      `RXIE_ADDR_PEND_LOWER:
      begin
        // Bits 7 and 3 carry no condition and read as zero
        d[`RXIE_LO_LENGTH]   = f[`RXIE_F_LENGTH];
        d[`RXIE_LO_COUNT]    = f[`RXIE_F_COUNT];
        d[`RXIE_LO_OVERFLOW] = f[`RXIE_F_OVERFLOW];
        d[`RXIE_LO_PARITY]   = f[`RXIE_F_PARITY];
        d[`RXIE_LO_PORT]     = f[`RXIE_F_PORT];
        d[`RXIE_LO_LOCK]     = f[`RXIE_F_LOCK];
      end
      `RXIE_ADDR_STATUS_FIRST:
      begin
        d[`RXIE_S1_LOCK_CHG]   = f[`RXIE_F_LOCK];
        d[`RXIE_S1_PORT_VALID] = port_valid;
        d[`RXIE_S1_PARITY]     = f[`RXIE_F_PARITY];
        d[`RXIE_S1_CHECK]      = f[`RXIE_F_CHECK];
        d[`RXIE_S1_ORDER]      = f[`RXIE_F_ORDER];
        d[`RXIE_S1_LOCK]       = lock;
      end
      `RXIE_ADDR_STATUS_SECOND:
      begin
        d[`RXIE_S2_COUNT]    = f[`RXIE_F_COUNT];
        d[`RXIE_S2_LENGTH]   = f[`RXIE_F_LENGTH];
        d[`RXIE_S2_CODING]   = f[`RXIE_F_CODING];
        d[`RXIE_S2_OVERFLOW] = f[`RXIE_F_OVERFLOW];
      end
      default:
      begin
        // Unmapped addresses read as zero
        d = 8'h00;
      end
    endcase
    read_byte = d;
  endfunction : read_byte

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = I_REG_RD;
    // Upper bits 7:3 are read-only zero; lower bits 7 and 3 are kept
    if (wr_upper)
    begin
      st_next.en_upper = I_REG_WDATA[2:0];
    end
    if (wr_lower)
    begin
      st_next.en_lower = I_REG_WDATA;
    end
    if (I_REG_RD)
    begin
      // Data is the value before any clear taken at this edge
      st_next.rdata = read_byte(I_REG_ADDR, st_reg.en_upper, st_reg.en_lower,
                                flags, I_LOCK, I_PORT_VALID);
    end
    st_next.irq = |pend_hit;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_NRST)
    begin
      // Pending flags and detectors reset inside their own modules
      st_reg.en_upper <= `RXIE_RST_EN_UPPER;
      st_reg.en_lower <= `RXIE_RST_EN_LOWER;
      st_reg.rdata    <= `RXIE_RST_RDATA;
      st_reg.rvalid   <= 1'b0;
      st_reg.irq      <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_REG_RDATA  = st_reg.rdata;
  assign O_REG_RVALID = st_reg.rvalid;
  assign O_IRQ        = st_reg.irq;

endmodule : rxie_top

// File: verif/rxie_top_sva.sv
// Port assertions of the receive-port interrupt block
`include "rxie_consts.svh"
module rxie_top_sva
(
  input wire logic        I_CLOCK,
  input wire logic        I_NRST,
  input wire logic [7:0]  I_REG_ADDR,
  input wire logic [7:0]  I_REG_WDATA,
  input wire logic        I_REG_WR,
  input wire logic        I_REG_RD,
  input wire logic [7:0]  O_REG_RDATA,
  input wire logic        O_REG_RVALID,
  input wire logic        I_LINK_CODING_ERR,
  input wire logic        I_CTRL_CHAN_ORDER_ERR,
  input wire logic        I_CTRL_CHAN_CHECK_ERR,
  input wire logic        I_LINK_PARITY_ERR,
  input wire logic        I_RX_OVERFLOW,
  input wire logic        I_LOCK,
  input wire logic        I_PORT_VALID,
  input wire logic [15:0] I_LINE_LENGTH,
  input wire logic [15:0] I_LINE_COUNT,
  input wire logic        O_IRQ
);
  // ******
  // Shadow of the enables, written through the register port
  // ******
  logic [2:0] en_up_reg;
  logic [7:0] en_lo_reg;
  logic       qw;
  logic       anyen;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_NRST);
  assign qw    = !I_REG_WR;
  assign anyen = |{en_up_reg, en_lo_reg[6:4], en_lo_reg[2:0]};
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_NRST)
    begin
      en_up_reg <= 3'h0;
      en_lo_reg <= 8'h00;
    end
    else if (I_REG_WR && I_REG_ADDR == `RXIE_ADDR_EN_UPPER)
      en_up_reg <= I_REG_WDATA[2:0];
    else if (I_REG_WR && I_REG_ADDR == `RXIE_ADDR_EN_LOWER)
      en_lo_reg <= I_REG_WDATA;
  end
  AST_CODING_IRQ: assert property (I_LINK_CODING_ERR && en_up_reg[2] && qw |=> ##1 O_IRQ)
    else $error("coding error gave no irq");
  AST_ORDER_IRQ: assert property (I_CTRL_CHAN_ORDER_ERR && en_up_reg[1] && qw |-> ##2 O_IRQ)
    else $error("order error gave no irq");
  AST_CHECK_IRQ: assert property (I_CTRL_CHAN_CHECK_ERR && en_up_reg[0] && qw ##1 1'b1 |=> O_IRQ)
    else $error("check error gave no irq");
  AST_OVERFLOW_IRQ: assert property (I_RX_OVERFLOW && en_lo_reg[4] && qw |=> ##1 O_IRQ)
    else $error("overflow gave no irq");
  AST_PARITY_IRQ: assert property (I_LINK_PARITY_ERR && en_lo_reg[2] && qw |-> ##2 O_IRQ)
    else $error("parity error gave no irq");
  AST_LENGTH_IRQ: assert property ($changed(I_LINE_LENGTH) && $past(I_NRST) && en_lo_reg[6]
    && qw ##1 qw |=> ##1 O_IRQ)
    else $error("length change gave no irq");
  AST_COUNT_IRQ: assert property ($changed(I_LINE_COUNT) && $past(I_NRST) && en_lo_reg[5]
    && qw ##1 qw |=> ##1 O_IRQ)
    else $error("count change gave no irq");
  AST_PORT_IRQ: assert property ($changed(I_PORT_VALID) && $past(I_NRST) && en_lo_reg[1]
    && qw ##1 qw |=> ##1 O_IRQ)
    else $error("port valid change gave no irq");
  AST_LOCK_IRQ: assert property ($changed(I_LOCK) && $past(I_NRST) && en_lo_reg[0]
    && qw ##1 qw |=> ##1 O_IRQ)
    else $error("lock change gave no irq");
  AST_RVALID_PULSE: assert property (O_REG_RVALID == $past(I_REG_RD))
    else $error("read valid not one cycle after read");
  AST_IRQ_GATED: assert property (O_IRQ |-> $past(anyen))
    else $error("irq without any enable");
endmodule : rxie_top_sva

bind rxie_top rxie_top_sva i_sva (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID), .I_LINK_CODING_ERR(I_LINK_CODING_ERR), .I_LOCK(I_LOCK),
  .I_CTRL_CHAN_ORDER_ERR(I_CTRL_CHAN_ORDER_ERR), .I_CTRL_CHAN_CHECK_ERR(I_CTRL_CHAN_CHECK_ERR),
  .I_LINK_PARITY_ERR(I_LINK_PARITY_ERR), .I_RX_OVERFLOW(I_RX_OVERFLOW), .I_PORT_VALID(I_PORT_VALID),
  .I_LINE_LENGTH(I_LINE_LENGTH), .I_LINE_COUNT(I_LINE_COUNT), .O_IRQ(O_IRQ));

// File: verif/rx_port_interrupt_enable_test.sv
// Self-checking bench of the receive-port interrupt block
module rx_port_interrupt_enable_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Stimulus, tables and counters
  // ******
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [4:0]  pulse;
  logic        lock;
  logic        port;
  logic [15:0] len;
  logic [15:0] cnt;
  logic        irq;
  int          n_mismatch;
  int          n_compared;
  int          cycles;
  // Per event: pending address and bit, status address and bit
  logic [7:0]  t_pa [9] = '{8'hDA, 8'hDA, 8'hDA, 8'hDB, 8'hDB, 8'hDB, 8'hDB, 8'hDB, 8'hDB};
  logic [7:0]  t_pb [9] = '{8'h04, 8'h02, 8'h01, 8'h04, 8'h10, 8'h01, 8'h02, 8'h20, 8'h40};
  logic [7:0]  t_sa [9] = '{8'hE1, 8'hE0, 8'hE0, 8'hE0, 8'hE1, 8'hE0, 8'hE0, 8'hE1, 8'hE1};
  logic [7:0]  t_sb [9] = '{8'h04, 8'h10, 8'h08, 8'h04, 8'h08, 8'h01, 8'h00, 8'h01, 8'h02};
  logic [7:0]  oth;

  rxie_top i_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr_stb), .I_REG_RD(rd_stb), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .I_LINK_CODING_ERR(pulse[0]), .I_CTRL_CHAN_ORDER_ERR(pulse[1]), .I_CTRL_CHAN_CHECK_ERR(pulse[2]),
    .I_LINK_PARITY_ERR(pulse[3]), .I_RX_OVERFLOW(pulse[4]), .I_LOCK(lock), .I_PORT_VALID(port),
    .I_LINE_LENGTH(len), .I_LINE_COUNT(cnt), .O_IRQ(irq));

  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      results();
    end
  end

  // ******
  // Access tasks
  // ******
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", exp, rdata);
  endtask : rd

  // First status carries the lock and port-valid levels beside its flags
  function automatic logic [7:0] st(input logic [7:0] a, input logic [7:0] b);
    return b | ((a == 8'hE0) ? {2'b00, lock, 3'b000, port, 1'b0} : 8'h00);
  endfunction : st

  task automatic fire(input int k);
    @(posedge clk);
    if (k < 5)
      pulse <= 5'h01 << k;
    else if (k == 5)
      lock <= ~lock;
    else if (k == 6)
      port <= ~port;
    else if (k == 7)
      cnt <= cnt + 16'h0001;
    else
      len <= len + 16'h0001;
    @(posedge clk);
    pulse <= 5'h00;
    tick(3);
  endtask : fire

  // ******
  // Tests
  // ******
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    {addr, wdata, wr_stb, rd_stb, pulse, lock, port, len, cnt} = '0;
    {n_mismatch, n_compared, cycles} = '0;
    tick(2);
    nrst <= 1'b1;
    foreach (t_pa[k])
      rd(t_sa[k] & 8'hFD, 8'h00);
    rd(8'hDA, 8'h00);
    rd(8'hDB, 8'h00);
    wr(8'hD8, 8'hFF);
    rd(8'hD8, 8'h07);
    wr(8'hD9, 8'hFF);
    rd(8'hD9, 8'hFF);
    wr(8'hDA, 8'hFF);
    rd(8'hDA, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h00);
    $display("register test done");
    for (int k = 0; k < 9; k++)
    begin
      oth = (t_sa[k] == 8'hE0) ? 8'hE1 : 8'hE0;
      fire(k);
      rd(t_pa[k], t_pb[k]);
      chk("irq", 8'h00, {7'h00, irq});
      wr(t_pa[k] - 8'h02, t_pb[k]);
      tick(2);
      chk("irq", 8'h01, {7'h00, irq});
      rd(oth, st(oth, 8'h00));
      rd(t_pa[k], t_pb[k]);
      rd(t_sa[k], st(t_sa[k], t_sb[k]));
      rd(t_pa[k], 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      fire(k);
      chk("irq", 8'h01, {7'h00, irq});
      rd(t_sa[k], st(t_sa[k], t_sb[k]));
      rd(t_pa[k], 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      wr(t_pa[k] - 8'h02, 8'h00);
      $display("event test %0d done", k);
    end
    wr(8'hD9, 8'h04);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= 8'hE0;
    pulse <= 5'h08;
    @(posedge clk);
    rd_stb <= 1'b0;
    pulse <= 5'h00;
    #1;
    chk("rdata", st(8'hE0, 8'h00), rdata);
    rd(8'hDB, 8'h04);
    chk("irq", 8'h01, {7'h00, irq});
    rd(8'hE0, st(8'hE0, 8'h04));
    tick(1);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    $display("same edge test done");
    results();
  end
endmodule : rx_port_interrupt_enable_test
